// ### core/serial_port_regs.vh
`ifndef SERIAL_PORT_REGS_VH
`define SERIAL_PORT_REGS_VH
// ----------------------------------------
// Register indices on the CPU register port
// ----------------------------------------
`define A_RX_LO 4'h0
`define A_RX_HI 4'h1
`define A_TX_LO 4'h2
`define A_TX_HI 4'h3
`define A_PCR 4'h4
`define A_SRG1 4'h5
`define A_SRG2 4'h6
`define A_CTRL 4'h7
`define A_STAT 4'h8
`define A_TXM_LO 4'h9
`define A_TXM_HI 4'hA
`define A_RXM_LO 4'hB
`define A_RXM_HI 4'hC
// ----------------------------------------
// Pin control register fields
// ----------------------------------------
`define P_RX_CLOCK_POLARITY 0
`define P_TX_CLOCK_POLARITY 1
`define P_RX_SYNC_POLARITY 2
`define P_TX_SYNC_POLARITY 3
`define P_ENHANCED_CLOCK_SELECT 7
`define P_RX_CLOCK_DIRECTION 8
`define P_TX_CLOCK_DIRECTION 9
`define P_RX_SYNC_DIRECTION 10
`define P_TX_SYNC_DIRECTION 11
`define PCR_WMASK 16'h3F8F
`define R16 16'h0000
`define R32 32'h00000000
// ----------------------------------------
// Rate generator and control fields
// ----------------------------------------
`define S_RATE_GEN_CLOCK_MODE 13
`define SRG2_WMASK 16'h2FFF
`define C_TXEN 0
`define C_RXEN 1
`define C_ALAW 5
`define C_CMP 6
`define C_MCH 9
`define C_STOP 10
`define C_SRGEN 11
`define ST_OVR 2
// ----------------------------------------
// Channel and companding constants
// ----------------------------------------
`define CH_LIM 7'h20
`define CH_LAST 7'h7F
`define MU_BIAS 16'h0084
`define MU_CLIP 16'h7F7B
`define A_XOR 8'h55
`endif

// ### core/serial_port.v
`timescale 1ns/1ns
`default_nettype none
`include "serial_port_regs.vh"
module serial_port (
  // Clock and reset.
  input wire MCLK,
  input wire RSTN,
  // CPU register port.
  input wire [3:0] REG_ADDR,
  input wire REG_WR,
  input wire REG_RD,
  input wire [15:0] REG_WDATA,
  output reg [15:0] REG_RDATA,
  // Events for CPU or DMA.
  output wire TX_EVENT,
  output wire RX_EVENT,
  // Transmit pins.
  input wire TX_BIT_CLOCK_PIN_I,
  output wire TX_BIT_CLOCK_PIN_O,
  output wire TX_BIT_CLOCK_PIN_OE,
  input wire TX_FRAME_SYNC_PIN_I,
  output wire TX_FRAME_SYNC_PIN_O,
  output wire TX_FRAME_SYNC_PIN_OE,
  output wire TX_SERIAL_DATA_PIN_O,
  output wire TX_SERIAL_DATA_PIN_OE,
  // Receive pins.
  input wire RX_BIT_CLOCK_PIN_I,
  output wire RX_BIT_CLOCK_PIN_O,
  output wire RX_BIT_CLOCK_PIN_OE,
  input wire RX_FRAME_SYNC_PIN_I,
  output wire RX_FRAME_SYNC_PIN_O,
  output wire RX_FRAME_SYNC_PIN_OE,
  input wire RX_SERIAL_DATA_PIN_I,
  // External rate clock.
  input wire EXTERNAL_RATE_CLOCK_PIN
);
  localparam [2:0] S_IDLE = 3'h1;
  localparam [2:0] S_DELAY = 3'h2;
  localparam [2:0] S_SHIFT = 3'h4;

  reg [5:0] s1_reg, s2_reg, s3_reg;
  reg [15:0] pcr_reg, srg1_reg, srg2_reg, ctrl_reg;
  reg [31:0] txm_reg, rxm_reg, dxr_reg, drr_reg, rbr_reg, xsr_reg, rsr_reg;
  reg tx_full_reg, drr_full_reg, rbr_full_reg, ovr_reg;
  reg [7:0] div_cnt_reg, wid_cnt_reg;
  reg [11:0] per_cnt_reg;
  reg srg_clk_reg, srg_fs_reg;
  reg [2:0] tx_st_reg, rx_st_reg;
  reg [1:0] tx_dly_reg, rx_dly_reg;
  reg [5:0] tx_bit_reg, rx_bit_reg;
  reg [6:0] tx_ch_reg, rx_ch_reg;
  reg tx_drive_reg, tx_out_reg, tx_clk_prev_reg, tx_fs_prev_reg;
  reg rx_clk_prev_reg, rx_fs_prev_reg;

  // ----------------------------------------
  // Companding and word length helpers
  // ----------------------------------------
  // Both laws share the segment search; mu-law adds its bias first.
  function [7:0] law_enc(input [15:0] s, input alaw);
    reg neg;
    reg [15:0] m, t;
    reg [2:0] seg;
    integer i;
    begin
      neg = s[15];
      m = neg ? (~s + 16'h0001) : s;
      if (m[15])
        m = 16'h7FFF;
      if (!alaw) begin
        if (m > `MU_CLIP)
          m = `MU_CLIP;
        m = m + `MU_BIAS;
      end
      seg = 3'h0;
      for (i = 8; i < 15; i = i + 1)
        if (m[i])
          seg = i[2:0] + 3'h1;
      t = (alaw && seg == 3'h0) ? (m >> 4) : (m >> ({1'b0, seg} + 4'h3));
      law_enc = alaw ? ({~neg, seg, t[3:0]} ^ `A_XOR) : ~{neg, seg, t[3:0]};
    end
  endfunction

  function [15:0] law_dec(input [7:0] c, input alaw);
    reg [7:0] u;
    reg [15:0] m;
    reg neg;
    begin
      u = alaw ? (c ^ `A_XOR) : ~c;
      neg = alaw ? ~u[7] : u[7];
      if (!alaw)
        m = ({8'h00, 1'b1, u[3:0], 3'h4} << u[6:4]) - `MU_BIAS;
      else if (u[6:4] == 3'h0)
        m = {8'h00, u[3:0], 4'h8};
      else
        m = {7'h00, 1'b1, u[3:0], 4'h8} << (u[6:4] - 3'h1);
      law_dec = neg ? (~m + 16'h0001) : m;
    end
  endfunction

  function [5:0] wbits(input [2:0] code);
    begin
      case (code)
        3'h0: wbits = 6'h08;
        3'h1: wbits = 6'h0C;
        3'h2: wbits = 6'h10;
        3'h3: wbits = 6'h14;
        3'h4: wbits = 6'h18;
        default: wbits = 6'h20;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Clock, sync and source selection
  // ----------------------------------------
  // Pin order: ext clock, rx data, rx sync, rx clock, tx sync, tx clock.
  wire [5:0] pin_raw = {EXTERNAL_RATE_CLOCK_PIN, RX_SERIAL_DATA_PIN_I, RX_FRAME_SYNC_PIN_I,
                        RX_BIT_CLOCK_PIN_I, TX_FRAME_SYNC_PIN_I, TX_BIT_CLOCK_PIN_I};
  wire [5:0] pin_rise = s2_reg & ~s3_reg;
  wire [1:0] src = {pcr_reg[`P_ENHANCED_CLOCK_SELECT], srg2_reg[`S_RATE_GEN_CLOCK_MODE]};
  wire stop = ctrl_reg[`C_STOP];
  wire cmp = ctrl_reg[`C_CMP];
  wire alaw = ctrl_reg[`C_ALAW];
  wire mch = ctrl_reg[`C_MCH];
  wire [5:0] nbits = cmp ? 6'h08 : wbits(ctrl_reg[4:2]);
  // Source ticks: ext pin, every CPU cycle, rx clock pin, tx clock pin.
  wire src_tick = (src == 2'b01) | ((src == 2'b00) & pin_rise[5]) |
                  ((src == 2'b10) & pin_rise[2]) | ((src == 2'b11) & pin_rise[0]);
  // Each direction picks its own clock and sync; clock-stop ties rx to tx.
  wire tx_clk = pcr_reg[`P_TX_CLOCK_DIRECTION] ? srg_clk_reg : s2_reg[0] ^ pcr_reg[`P_TX_CLOCK_POLARITY];
  wire tx_fs = pcr_reg[`P_TX_SYNC_DIRECTION] ? srg_fs_reg : s2_reg[1] ^ pcr_reg[`P_TX_SYNC_POLARITY];
  wire rx_clk = stop ? tx_clk :
                (pcr_reg[`P_RX_CLOCK_DIRECTION] ? srg_clk_reg : s2_reg[2] ^ pcr_reg[`P_RX_CLOCK_POLARITY]);
  wire rx_fs = stop ? tx_fs :
               (pcr_reg[`P_RX_SYNC_DIRECTION] ? srg_fs_reg : s2_reg[3] ^ pcr_reg[`P_RX_SYNC_POLARITY]);
  wire tx_rise = tx_clk & ~tx_clk_prev_reg;
  wire rx_fall = ~rx_clk & rx_clk_prev_reg;
  wire tx_start = tx_fs & ~tx_fs_prev_reg & ctrl_reg[`C_TXEN];
  wire rx_start = rx_fs & ~rx_fs_prev_reg & ctrl_reg[`C_RXEN];
  wire tx_ch_en = ~mch | ((tx_ch_reg < `CH_LIM) & txm_reg[tx_ch_reg[4:0]]);
  // The channel that the next word belongs to, so words follow with no gap bit.
  wire [6:0] tx_ch_nx = tx_ch_reg + 7'h01;
  wire tx_en_first = ~mch | txm_reg[0];
  wire tx_en_nx = ~mch | ((tx_ch_nx < `CH_LIM) & txm_reg[tx_ch_nx[4:0]]);
  wire rx_ch_en = ~mch | ((rx_ch_reg < `CH_LIM) & rxm_reg[rx_ch_reg[4:0]]);
  wire [31:0] tx_word = cmp ? {law_enc(dxr_reg[15:0], alaw), 24'h000000}
                            : (dxr_reg << (6'h20 - nbits));
  wire [31:0] rx_new = {rsr_reg[30:0], s2_reg[4]};
  wire [31:0] rx_val = cmp ? {{16{1'b0}}, law_dec(rx_new[7:0], alaw)}
                           : (rx_new & ~(32'hFFFFFFFF << nbits));

  // ----------------------------------------
  // Pins and events
  // ----------------------------------------
  // A clock pin feeding the rate generator is kept an input.
  assign TX_BIT_CLOCK_PIN_O = srg_clk_reg ^ pcr_reg[`P_TX_CLOCK_POLARITY];
  assign TX_BIT_CLOCK_PIN_OE = pcr_reg[`P_TX_CLOCK_DIRECTION] & (src != 2'b11);
  assign RX_BIT_CLOCK_PIN_O = srg_clk_reg ^ pcr_reg[`P_RX_CLOCK_POLARITY];
  assign RX_BIT_CLOCK_PIN_OE = pcr_reg[`P_RX_CLOCK_DIRECTION] & (src != 2'b10) & ~stop;
  assign TX_FRAME_SYNC_PIN_O = srg_fs_reg ^ pcr_reg[`P_TX_SYNC_POLARITY];
  assign TX_FRAME_SYNC_PIN_OE = pcr_reg[`P_TX_SYNC_DIRECTION];
  assign RX_FRAME_SYNC_PIN_O = srg_fs_reg ^ pcr_reg[`P_RX_SYNC_POLARITY];
  assign RX_FRAME_SYNC_PIN_OE = pcr_reg[`P_RX_SYNC_DIRECTION] & ~stop;
  assign TX_SERIAL_DATA_PIN_O = tx_out_reg;
  assign TX_SERIAL_DATA_PIN_OE = tx_drive_reg;
  assign TX_EVENT = ~tx_full_reg & ctrl_reg[`C_TXEN];
  assign RX_EVENT = drr_full_reg;

  // Starts a transmit word on this edge; disabled channels float the pin.
  task tx_load(input en);
    begin
      tx_drive_reg <= en;
      tx_out_reg <= tx_word[31];
      xsr_reg <= tx_word << 1;
      tx_bit_reg <= nbits - 6'h01;
      tx_st_reg <= S_SHIFT;
      if (en)
        tx_full_reg <= 1'b0;
    end
  endtask

  // ----------------------------------------
  // Registers, rate generator and shifters
  // ----------------------------------------
  // One process owns every flag so that a hardware set can win over a clear.
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      s1_reg <= 6'h00;
      s2_reg <= 6'h00;
      s3_reg <= 6'h00;
      pcr_reg <= `R16;
      srg1_reg <= `R16;
      srg2_reg <= `R16;
      ctrl_reg <= `R16;
      txm_reg <= `R32;
      rxm_reg <= `R32;
      dxr_reg <= `R32;
      drr_reg <= `R32;
      rbr_reg <= `R32;
      xsr_reg <= `R32;
      rsr_reg <= `R32;
      tx_full_reg <= 1'b0;
      drr_full_reg <= 1'b0;
      rbr_full_reg <= 1'b0;
      ovr_reg <= 1'b0;
      div_cnt_reg <= 8'h00;
      wid_cnt_reg <= 8'h00;
      per_cnt_reg <= 12'h000;
      srg_clk_reg <= 1'b0;
      srg_fs_reg <= 1'b0;
      tx_st_reg <= S_IDLE;
      rx_st_reg <= S_IDLE;
      tx_dly_reg <= 2'h0;
      rx_dly_reg <= 2'h0;
      tx_bit_reg <= 6'h00;
      rx_bit_reg <= 6'h00;
      tx_ch_reg <= 7'h00;
      rx_ch_reg <= 7'h00;
      tx_drive_reg <= 1'b0;
      tx_out_reg <= 1'b0;
      tx_clk_prev_reg <= 1'b0;
      tx_fs_prev_reg <= 1'b0;
      rx_clk_prev_reg <= 1'b0;
      rx_fs_prev_reg <= 1'b0;
      REG_RDATA <= `R16;
    end else begin
      // All pins pass two flops; the third stage only serves edge finding.
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      tx_clk_prev_reg <= tx_clk;
      rx_clk_prev_reg <= rx_clk;
      // Rate generator; a toggle per tick caps the bit clock at half rate.
      if (ctrl_reg[`C_SRGEN] && src_tick) begin
        if (div_cnt_reg == 8'h00) begin
          div_cnt_reg <= srg1_reg[7:0];
          srg_clk_reg <= ~srg_clk_reg;
          if (!srg_clk_reg) begin
            if (per_cnt_reg == 12'h000) begin
              per_cnt_reg <= srg2_reg[11:0];
              wid_cnt_reg <= srg1_reg[15:8];
              srg_fs_reg <= 1'b1;
            end else begin
              per_cnt_reg <= per_cnt_reg - 12'h001;
              if (wid_cnt_reg == 8'h00)
                srg_fs_reg <= 1'b0;
              else
                wid_cnt_reg <= wid_cnt_reg - 8'h01;
            end
          end
        end else begin
          div_cnt_reg <= div_cnt_reg - 8'h01;
        end
      end
      // Transmitter: data launched on the rising bit clock.
      if (tx_rise) begin
        tx_fs_prev_reg <= tx_fs;
        case (tx_st_reg)
          S_IDLE: begin
            if (tx_start) begin
              tx_ch_reg <= 7'h00;
              tx_dly_reg <= ctrl_reg[8:7] - 2'h1;
              if (ctrl_reg[8:7] == 2'h0)
                tx_load(tx_en_first);
              else
                tx_st_reg <= S_DELAY;
            end
          end
          S_DELAY: begin
            if (tx_dly_reg == 2'h0)
              tx_load(tx_ch_en);
            else
              tx_dly_reg <= tx_dly_reg - 2'h1;
          end
          S_SHIFT: begin
            if (tx_bit_reg != 6'h00) begin
              tx_out_reg <= xsr_reg[31];
              xsr_reg <= xsr_reg << 1;
              tx_bit_reg <= tx_bit_reg - 6'h01;
            end else if (tx_start) begin
              tx_ch_reg <= 7'h00;
              tx_drive_reg <= 1'b0;
              tx_dly_reg <= ctrl_reg[8:7] - 2'h1;
              tx_st_reg <= (ctrl_reg[8:7] == 2'h0) ? S_IDLE : S_DELAY;
            end else if (mch && tx_ch_reg != `CH_LAST) begin
              tx_ch_reg <= tx_ch_nx;
              tx_load(tx_en_nx);
            end else begin
              tx_drive_reg <= 1'b0;
              tx_st_reg <= S_IDLE;
            end
          end
          default: tx_st_reg <= S_IDLE;
        endcase
      end
      // Buffer moves into the data register only when that is empty.
      if (REG_RD && REG_ADDR == `A_RX_LO)
        drr_full_reg <= 1'b0;
      if (rbr_full_reg && !drr_full_reg) begin
        drr_reg <= rbr_reg;
        drr_full_reg <= 1'b1;
        rbr_full_reg <= 1'b0;
      end
      // Receiver: data sampled on the falling bit clock.
      if (rx_fall) begin
        rx_fs_prev_reg <= rx_fs;
        case (rx_st_reg)
          S_IDLE: begin
            if (rx_start) begin
              rx_ch_reg <= 7'h00;
              rx_dly_reg <= ctrl_reg[8:7] - 2'h1;
              rx_st_reg <= (ctrl_reg[8:7] == 2'h0) ? S_SHIFT : S_DELAY;
              rx_bit_reg <= nbits - 6'h01;
              rsr_reg <= rx_new;
            end
          end
          S_DELAY: begin
            if (rx_dly_reg == 2'h0) begin
              rx_st_reg <= S_SHIFT;
              rx_bit_reg <= nbits - 6'h01;
              rsr_reg <= rx_new;
            end else begin
              rx_dly_reg <= rx_dly_reg - 2'h1;
            end
          end
          S_SHIFT: begin
            rsr_reg <= rx_new;
            if (rx_bit_reg != 6'h01) begin
              rx_bit_reg <= rx_bit_reg - 6'h01;
            end else begin
              // A full buffer keeps its word; the new one is lost as an overrun.
              if (rx_ch_en) begin
                if (rbr_full_reg && drr_full_reg) begin
                  ovr_reg <= 1'b1;
                end else begin
                  rbr_reg <= rx_val;
                  rbr_full_reg <= 1'b1;
                end
              end
              rx_bit_reg <= nbits;
              rx_ch_reg <= rx_ch_reg + 7'h01;
              if (!mch || rx_ch_reg == `CH_LAST)
                rx_st_reg <= S_IDLE;
            end
          end
          default: rx_st_reg <= S_IDLE;
        endcase
      end
      // CPU writes; a data write sets the full flag after any consume.
      if (REG_WR) begin
        case (REG_ADDR)
          `A_TX_LO: begin
            dxr_reg[15:0] <= REG_WDATA;
            tx_full_reg <= 1'b1;
          end
          `A_TX_HI: dxr_reg[31:16] <= REG_WDATA;
          `A_PCR: pcr_reg <= REG_WDATA & `PCR_WMASK;
          `A_SRG1: srg1_reg <= REG_WDATA;
          `A_SRG2: srg2_reg <= REG_WDATA & `SRG2_WMASK;
          `A_CTRL: ctrl_reg <= REG_WDATA;
          `A_STAT: if (REG_WDATA[`ST_OVR] && !(rx_fall && rbr_full_reg)) ovr_reg <= 1'b0;
          `A_TXM_LO: txm_reg[15:0] <= REG_WDATA;
          `A_TXM_HI: txm_reg[31:16] <= REG_WDATA;
          `A_RXM_LO: rxm_reg[15:0] <= REG_WDATA;
          `A_RXM_HI: rxm_reg[31:16] <= REG_WDATA;
          default: ;
        endcase
      end
      // Read data; the pin control status bits show live pin levels.
      case (REG_ADDR)
        `A_RX_LO: REG_RDATA <= drr_reg[15:0];
        `A_RX_HI: REG_RDATA <= drr_reg[31:16];
        `A_TX_LO: REG_RDATA <= dxr_reg[15:0];
        `A_TX_HI: REG_RDATA <= dxr_reg[31:16];
        `A_PCR: REG_RDATA <= {pcr_reg[15:7], s2_reg[5], tx_out_reg, s2_reg[4],
                              pcr_reg[3:0]};
        `A_SRG1: REG_RDATA <= srg1_reg;
        `A_SRG2: REG_RDATA <= srg2_reg;
        `A_CTRL: REG_RDATA <= ctrl_reg;
        `A_STAT: REG_RDATA <= {13'h0000, ovr_reg, drr_full_reg, ~tx_full_reg};
        `A_TXM_LO: REG_RDATA <= txm_reg[15:0];
        `A_TXM_HI: REG_RDATA <= txm_reg[31:16];
        `A_RXM_LO: REG_RDATA <= rxm_reg[15:0];
        `A_RXM_HI: REG_RDATA <= rxm_reg[31:16];
        default: REG_RDATA <= `R16;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### verif/serial_port_sva.sv
`timescale 1ns/1ns
`default_nettype none
module serial_port_sva (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RSTN,
  // Register port.
  input wire logic [3:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [15:0] REG_WDATA,
  input wire logic [15:0] REG_RDATA,
  // Event and pins.
  input wire logic TX_EVENT,
  input wire logic TX_BIT_CLOCK_PIN_OE,
  input wire logic TX_FRAME_SYNC_PIN_OE,
  input wire logic RX_BIT_CLOCK_PIN_OE,
  input wire logic RX_SERIAL_DATA_PIN_I
);
  logic [15:0] pcr_reg;
  logic rate_gen_clock_mode_reg;
  logic txen_reg;
  logic rxd_reg;
  logic [2:0] calm_reg;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RSTN);
  // Shadow of the control bits, so pin enables can be predicted.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      pcr_reg <= 16'h0000;
      rate_gen_clock_mode_reg <= 1'h0;
      txen_reg <= 1'h0;
      rxd_reg <= 1'h0;
      calm_reg <= 3'h0;
    end else begin
      rxd_reg <= RX_SERIAL_DATA_PIN_I;
      if (RX_SERIAL_DATA_PIN_I != rxd_reg)
        calm_reg <= 3'h0;
      else if (calm_reg != 3'h7)
        calm_reg <= calm_reg + 3'h1;
      if (REG_WR && REG_ADDR == 4'h4)
        pcr_reg <= REG_WDATA & 16'h3F8F;
      if (REG_WR && REG_ADDR == 4'h6)
        rate_gen_clock_mode_reg <= REG_WDATA[13];
      if (REG_WR && REG_ADDR == 4'h7)
        txen_reg <= REG_WDATA[0];
    end
  end
  // The pin level is only compared once it has been still long enough to cross the flops.
  a_pcr_readback: assert property ($past(REG_ADDR) == 4'h4 && !$past(REG_WR) |->
    (REG_RDATA & 16'hFF8F) == pcr_reg) else $error("pin control readback wrong");
  a_rx_level_bit: assert property ($past(REG_ADDR) == 4'h4 && calm_reg == 3'h7 |->
    REG_RDATA[4] == RX_SERIAL_DATA_PIN_I) else $error("rx data level bit wrong");
  a_rx_clk_off: assert property ((pcr_reg[7] && !rate_gen_clock_mode_reg)[*2] |->
    !RX_BIT_CLOCK_PIN_OE) else $error("rx clock driven while it is the source");
  a_tx_clk_off: assert property ((pcr_reg[7] && rate_gen_clock_mode_reg)[*2] |->
    !TX_BIT_CLOCK_PIN_OE) else $error("tx clock driven while it is the source");
  a_tx_clk_drive: assert property ((pcr_reg[9:7] == 3'h7 && !rate_gen_clock_mode_reg)[*2] |->
    TX_BIT_CLOCK_PIN_OE) else $error("tx clock not driven from generator");
  a_tx_sync_dir: assert property ($stable(pcr_reg[11]) |->
    TX_FRAME_SYNC_PIN_OE == pcr_reg[11]) else $error("tx sync direction wrong");
  a_tx_event_off: assert property ((!txen_reg)[*2] |-> !TX_EVENT)
    else $error("tx event while tx disabled");
  a_tx_event_fall: assert property (REG_WR && REG_ADDR == 4'h2 |=> !TX_EVENT)
    else $error("tx event stays after data write");
  c_pcr_read: cover property ($past(REG_ADDR) == 4'h4 && calm_reg == 3'h7);
  c_rx_source: cover property (pcr_reg[9:7] == 3'h7 && !rate_gen_clock_mode_reg);
  c_tx_write: cover property (REG_WR && REG_ADDR == 4'h2 && TX_EVENT);
endmodule
`default_nettype wire

// ### verif/codec_model.sv
`timescale 1ns/1ns
`default_nettype none
module codec_model (
  // Link pins as the far side sees them.
  output logic bclk,
  output logic fsync,
  output logic sdo,
  input wire logic sdi
);
  logic [31:0] got;
  // The clock stands still low between frames.
  initial begin
    bclk = 1'h0;
    fsync = 1'h0;
    sdo = 1'h0;
    got = 32'h0;
  end
  // Data changes at the rise so it is settled at the fall; the port's bit is read
  // one rise late because it crosses two flops before it leaves.
  task automatic frame(input int n, input logic [31:0] word);
    int i;
    begin
      got = 32'h0;
      for (i = 0; i <= n; i++) begin
        bclk = 1'h1;
        fsync = (i == 0);
        if (i > 0)
          got = {got[30:0], sdi};
        sdo = (i < n) ? word[n - 1 - i] : ~sdo;
        #200;
        bclk = 1'h0;
        #200;
      end
    end
  endtask
endmodule
`default_nettype wire

// ### verif/serial_port_bench.sv
`timescale 1ns/1ns
`default_nettype none
module serial_port_bench;
  logic mclk, rstn, wr, rd, ext_clk;
  logic [3:0] addr;
  logic [15:0] wdata, v, hi;
  logic [31:0] tw, rw, m;
  wire [15:0] rdata;
  wire tx_ev, rx_ev, tck_o, tck_oe, tfs_o, tfs_oe, tdo, tdo_oe;
  wire rck_o, rck_oe, rfs_o, rfs_oe, bclk, fsync, sdo;
  int n_fail, total_checks, n, s, c;
  // A pin the port drives shows its own level, otherwise the far side's.
  wire tck = tck_oe ? tck_o : bclk;
  wire tfs = tfs_oe ? tfs_o : fsync;
  wire rck = rck_oe ? rck_o : bclk;
  wire rfs = rfs_oe ? rfs_o : fsync;
  // Clock.
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  serial_port u_dut (
    .MCLK(mclk), .RSTN(rstn), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .TX_EVENT(tx_ev), .RX_EVENT(rx_ev),
    .TX_BIT_CLOCK_PIN_I(tck), .TX_BIT_CLOCK_PIN_O(tck_o), .TX_BIT_CLOCK_PIN_OE(tck_oe),
    .TX_FRAME_SYNC_PIN_I(tfs), .TX_FRAME_SYNC_PIN_O(tfs_o), .TX_FRAME_SYNC_PIN_OE(tfs_oe),
    .TX_SERIAL_DATA_PIN_O(tdo), .TX_SERIAL_DATA_PIN_OE(tdo_oe),
    .RX_BIT_CLOCK_PIN_I(rck), .RX_BIT_CLOCK_PIN_O(rck_o), .RX_BIT_CLOCK_PIN_OE(rck_oe),
    .RX_FRAME_SYNC_PIN_I(rfs), .RX_FRAME_SYNC_PIN_O(rfs_o), .RX_FRAME_SYNC_PIN_OE(rfs_oe),
    .RX_SERIAL_DATA_PIN_I(sdo), .EXTERNAL_RATE_CLOCK_PIN(ext_clk)
  );
  codec_model u_codec (.bclk(bclk), .fsync(fsync), .sdo(sdo), .sdi(tdo));
  // ----
  // Tasks
  // ----
  // Register accesses launch just after an edge and hold until the next one.
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    begin
      @(posedge mclk) #2;
      addr = a;
      wdata = d;
      wr = 1'h1;
      @(posedge mclk) #2;
      wr = 1'h0;
    end
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    begin
      @(posedge mclk) #2;
      addr = a;
      rd = (a == 4'h0);
      @(posedge mclk) #2;
      rd = 1'h0;
      d = rdata;
    end
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    begin
      total_checks++;
      if (g !== e) begin
        n_fail++;
        $display("BAD %s expected %h seen %h", what, e, g);
      end
    end
  endtask
  task automatic tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask
  // A hung handshake ends the run here as a failure.
  initial begin
    #1000000;
    n_fail++;
    tally_and_finish;
  end
  // ----
  // Tests
  // ----
  initial begin
    rstn = 1'h0;
    wr = 1'h0;
    rd = 1'h0;
    addr = 4'h0;
    wdata = 16'h0000;
    ext_clk = 1'h0;
    n_fail = 0;
    total_checks = 0;
    tw = $urandom(32'hE2B1EBEC);
    repeat (12) @(posedge mclk);
    #2 rstn = 1'h1;
    // Reset values; the last three places are unmapped and read zero.
    for (c = 0; c < 16; c++) begin
      rd_reg(c[3:0], v);
      if (c != 8) chk("reset value", 32'h0, {16'h0000, v});
    end
    repeat (8) begin
      tw = $urandom;
      wr_reg(4'h4, tw[15:0]);
      rd_reg(4'h4, v);
      chk("pin control", {16'h0000, tw[15:0] & 16'h3F8F}, {16'h0000, v});
    end
    ext_clk = 1'h1;
    repeat (4) @(posedge mclk);
    rd_reg(4'h4, v);
    chk("ext clock level", 32'h1, {31'h0, v[6]});
    // Every generator source with both clock directions set to output.
    for (s = 0; s < 4; s++) begin
      wr_reg(4'h6, {2'h0, s[0], 13'h0000});
      wr_reg(4'h4, {8'h03, s[1], 7'h00});
      repeat (2) @(posedge mclk);
      chk("clock enables", {30'h0, s != 3, s != 2}, {30'h0, tck_oe, rck_oe});
    end
    wr_reg(4'h4, 16'h0000);
    wr_reg(4'h6, 16'h0000);
    ext_clk = 1'h0;
    // Each word length, both directions at once from the far side's clock.
    for (c = 0; c < 6; c++) begin
      n = (c == 5) ? 32 : 8 + 4 * c;
      m = (n == 32) ? 32'hFFFFFFFF : (32'h1 << n) - 32'h1;
      tw = $urandom;
      rw = $urandom;
      wr_reg(4'h7, {11'h000, c[2:0], 2'h3});
      wr_reg(4'h3, tw[31:16]);
      wr_reg(4'h2, tw[15:0]);
      u_codec.frame(n, rw);
      repeat (8) @(posedge mclk);
      chk("tx word", tw & m, u_codec.got);
      chk("rx event", 32'h1, {31'h0, rx_ev});
      rd_reg(4'h4, v);
      chk("rx level", {31'h0, ~rw[0]}, {31'h0, v[4]});
      rd_reg(4'h1, hi);
      rd_reg(4'h0, v);
      chk("rx word", rw & m, {hi, v} & m);
    end
    // Three words arrive unread: the third finds both stages full.
    wr_reg(4'h7, 16'h000A);
    tw = $urandom;
    rw = $urandom;
    u_codec.frame(16, tw);
    u_codec.frame(16, rw);
    u_codec.frame(16, 32'h0000A5C3);
    repeat (8) @(posedge mclk);
    rd_reg(4'h8, v);
    chk("overrun", 32'h1, {31'h0, v[2]});
    rd_reg(4'h0, v);
    chk("first word", tw & 32'hFFFF, {16'h0000, v});
    repeat (4) @(posedge mclk);
    rd_reg(4'h0, v);
    chk("second word", rw & 32'hFFFF, {16'h0000, v});
    rd_reg(4'h0, v);
    wr_reg(4'h8, 16'h0004);
    rd_reg(4'h8, v);
    chk("overrun clear", 32'h0, {31'h0, v[2]});
    // Next word written while the current one is on the wire.
    wr_reg(4'h7, 16'h0009);
    tw = $urandom;
    wr_reg(4'h2, tw[15:0]);
    chk("tx full", 32'h0, {31'h0, tx_ev});
    fork
      u_codec.frame(16, 32'h0);
      begin
        repeat (30) @(posedge mclk);
        chk("tx empty", 32'h1, {31'h0, tx_ev});
        wr_reg(4'h2, tw[31:16]);
      end
    join
    chk("tx first", tw & 32'hFFFF, u_codec.got);
    u_codec.frame(16, 32'h0);
    chk("tx second", tw >> 16, u_codec.got);
    // Mu-law: zero encodes to all ones, code 80 expands to the largest positive step.
    wr_reg(4'h7, 16'h0043);
    wr_reg(4'h2, 16'h0000);
    u_codec.frame(8, 32'h00000080);
    repeat (8) @(posedge mclk);
    chk("mu encode", 32'hFF, u_codec.got);
    rd_reg(4'h0, v);
    chk("mu expand", 32'h7D7C, {16'h0000, v});
    // Multichannel: only channel 1 is enabled each way, channel 0 is skipped.
    wr_reg(4'h9, 16'h0002);
    wr_reg(4'hB, 16'h0002);
    wr_reg(4'h7, 16'h0203);
    tw = $urandom;
    rw = $urandom;
    wr_reg(4'h2, tw[15:0]);
    u_codec.frame(16, rw);
    repeat (8) @(posedge mclk);
    chk("mch tx word", tw & 32'hFF, u_codec.got & 32'hFF);
    rd_reg(4'h0, v);
    chk("mch rx word", rw & 32'hFF, {16'h0000, v});
    tally_and_finish;
  end
endmodule
bind serial_port serial_port_sva u_sva (
  .MCLK(MCLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA), .TX_EVENT(TX_EVENT), .TX_BIT_CLOCK_PIN_OE(TX_BIT_CLOCK_PIN_OE),
  .TX_FRAME_SYNC_PIN_OE(TX_FRAME_SYNC_PIN_OE), .RX_BIT_CLOCK_PIN_OE(RX_BIT_CLOCK_PIN_OE),
  .RX_SERIAL_DATA_PIN_I(RX_SERIAL_DATA_PIN_I)
);
`default_nettype wire
